// ---- design/sid_regs.svh ----
`ifndef SID_REGS_SVH
`define SID_REGS_SVH
// opcodes
`define SID_OP_SET_LATCH   8'h06
`define SID_OP_CLR_LATCH   8'h04
`define SID_OP_STAT_WR     8'h01
`define SID_OP_STAT_RD     8'h05
`define SID_OP_RESTORE     8'h07
`define SID_OP_MEM_WR_LO   3'h2
`define SID_OP_MEM_RD_LO   3'h3
// nonvolatile status bits b7:b2 kept as nv[5:0]
`define SID_NV_RESET       6'h00
`define SID_NV_LOCK        5
`define SID_NV_RANGE       4
`define SID_NV_DOG_HI      3
`define SID_NV_DOG_LO      2
`define SID_NV_BLK_HI      1
`define SID_NV_BLK_LO      0
// address map used by the write guard
`define SID_BLK_Q3         9'h0c0
`define SID_BLK_HALF       9'h080
`define SID_REG_BASE       9'h100
`define SID_REG_FIRST_WR   9'h10a
`define SID_ROM_BASE       9'h110
`define SID_HR_BASE        9'h120
`define SID_HR_LAST        9'h135
`endif

// ---- design/sid_pkg.sv ----
package sid_pkg;
  // byte phase of one chip-select frame
  typedef enum logic [2:0] {
    SID_PH_IDLE,
    SID_PH_OPCODE,
    SID_PH_ADDR,
    SID_PH_WDATA,
    SID_PH_SDATA,
    SID_PH_TX,
    SID_PH_IGNORE
  } sid_phase_t;
endpackage : sid_pkg

// ---- design/sid_decoder.sv ----
`timescale 1ns/1ps
`include "sid_regs.svh"

// three-stage input filter: a change counts once stages two and three agree
module sid_sync3 #(
  parameter int         WIDTH   = 1,
  parameter logic [3:0] RST_VAL = 4'h0
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] filt_out
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q; // s1 only feeds s2

  // shift chain, reset to idle pin levels
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_q     <= RST_VAL[WIDTH-1:0];
      s2_q     <= RST_VAL[WIDTH-1:0];
      s3_q     <= RST_VAL[WIDTH-1:0];
      filt_out <= RST_VAL[WIDTH-1:0];
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // per bit: take stage three only when it matches stage two
      filt_out <= (s2_q & s3_q) | (filt_out & (s2_q | s3_q));
    end
  end
endmodule : sid_sync3

// write buffer between the serial decoder and the nv engine
module sid_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic      [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];   // storage, no reset needed
  logic [AW-1:0]    wr_ptr_q;         // next slot to fill
  logic [AW-1:0]    rd_ptr_q;         // next slot to drain
  logic [AW:0]      cnt_q;            // words held
  logic             push, pop;

  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;
  assign out_data_out  = mem_q[rd_ptr_q];

  // storage write
  always_ff @(posedge clk_sys_in) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_in;
    end
  end

  // pointers, count and registered full/empty flags
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_q      <= '0;
      rd_ptr_q      <= '0;
      cnt_q         <= '0;
      in_ready_out  <= 1'b1;
      out_valid_out <= 1'b0;
    end else begin
      if (push) wr_ptr_q <= wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= rd_ptr_q + 1'b1;
      unique case ({push, pop})
        2'b10: begin
          cnt_q         <= cnt_q + 1'b1;
          in_ready_out  <= (cnt_q != (AW+1)'(DEPTH - 1));
          out_valid_out <= 1'b1;
        end
        2'b01: begin
          cnt_q         <= cnt_q - 1'b1;
          in_ready_out  <= 1'b1;
          out_valid_out <= (cnt_q != (AW+1)'(1));
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end
endmodule : sid_fifo

module sid_decoder
  import sid_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       chip_select_low_in,      // serial select pin
  input  wire logic       sck_in,                  // serial clock pin
  input  wire logic       si_in,                   // serial data in pin
  input  wire logic       hw_protect_pin_low_in,   // protect pin, low protects
  output logic            so_out,                  // serial data out
  output logic            so_oe_n_out,             // low while driving so
  output logic            mode_idle_high_out,      // 1 = mode (1,1)
  input  wire logic       nv_busy_in,              // nv write cycle running
  output logic            mem_wr_valid_out,        // buffered write word
  input  wire logic       mem_wr_ready_in,
  output logic [8:0]      mem_wr_addr_out,
  output logic [7:0]      mem_wr_data_out,
  output logic            mem_commit_out,          // start programming, pulse
  output logic            mem_abort_out,           // drop buffered bytes, pulse
  output logic            status_commit_out,       // nv status bits changed, pulse
  output logic            mem_rd_req_out,          // read strobe, pulse
  output logic [8:0]      mem_rd_addr_out,
  input  wire logic [7:0] mem_rd_data_in,          // valid cycle after strobe
  output logic            restore_defaults_out,    // reload 120h-125h, pulse
  output logic            status_lock_enable_out,
  output logic            high_range_guard_out,
  output logic [1:0]      dog_timeout_sel_out,
  output logic [1:0]      block_guard_sel_out
);
  logic [3:0]  pins_f;                // filtered cs, sck, si, protect pin
  logic        cs_f, sck_f, si_f, wp_f;
  logic        cs_prev_q, sck_prev_q; // previous filtered levels
  logic        cs_fall, cs_rise, sck_rise, sck_fall;
  sid_phase_t  phase_q;               // byte phase
  logic [2:0]  bit_cnt_q;             // received bits in byte
  logic [6:0]  rx_sh_q;               // received bits, msb first
  logic [7:0]  rx_byte;
  logic        byte_done;
  logic        is_read_q;             // address byte belongs to a read
  logic        addr_hi_q;             // ninth address bit from opcode
  logic [8:0]  addr_q;                // running byte address
  logic        latch_q;               // write-enable latch
  logic        write_busy_flag;       // nv cycle busy, status bit 0
  logic        busy_q;
  logic [5:0]  nv_q;                  // status bits b7:b2
  logic [7:0]  sdata_q;               // last status byte received
  logic        sdata_got_q;
  logic        pushed_q, overrun_q;   // write frame bookkeeping
  logic        lock_now;              // nv status bits write-locked
  logic        addr_ok;               // target address writable
  logic        push;
  logic [2:0]  tx_cnt_q;
  logic [6:0]  tx_sh_q;
  logic        tx_src_stat_q;         // transmit status, else memory
  logic [7:0]  stat_byte, next_byte;
  logic        rd_pend_q;
  logic [7:0]  rd_data_q;
  logic        fifo_in_ready;
  logic [16:0] fifo_out;

  sid_sync3 #(.WIDTH(4), .RST_VAL(4'h9)) u_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({hw_protect_pin_low_in, si_in, sck_in, chip_select_low_in}),
    .filt_out   (pins_f)
  );
  assign {wp_f, si_f, sck_f, cs_f} = pins_f;

  // edge finders on the filtered pins; sck edges only count while selected
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_prev_q  <= 1'b1;
      sck_prev_q <= 1'b0;
    end else begin
      cs_prev_q  <= cs_f;
      sck_prev_q <= sck_f;
    end
  end
  assign cs_fall  = cs_prev_q & ~cs_f;
  assign cs_rise  = ~cs_prev_q & cs_f;
  assign sck_rise = ~sck_prev_q & sck_f & ~cs_f & ~cs_prev_q;
  assign sck_fall = sck_prev_q & ~sck_f & ~cs_f & ~cs_prev_q;

  // mode latched at select fall; in (1,1) the lone leading fall finds no tx
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mode_idle_high_out <= 1'b0;
    end else if (cs_fall) begin
      mode_idle_high_out <= sck_f;
    end
  end

  // receive shifter, msb first, one byte per eight rises
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bit_cnt_q <= 3'h0;
      rx_sh_q   <= 7'h00;
    end else if (cs_fall) begin
      bit_cnt_q <= 3'h0;
    end else if (sck_rise) begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_sh_q   <= {rx_sh_q[5:0], si_f};
    end
  end
  assign rx_byte   = {rx_sh_q, si_f};
  assign byte_done = sck_rise & (bit_cnt_q == 3'h7);

  // busy flag from the nv engine, shown as status bit 0
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) busy_q <= 1'b0;
    else           busy_q <= nv_busy_in;
  end
  assign write_busy_flag = busy_q;
  // status is not memory mapped; it is only this byte
  assign stat_byte = {nv_q, latch_q, write_busy_flag};
  assign lock_now  = nv_q[`SID_NV_LOCK] & ~wp_f;

  // byte phase machine; busy refuses all but the status read
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_q   <= SID_PH_IDLE;
      is_read_q <= 1'b0;
      addr_hi_q <= 1'b0;
    end else if (cs_fall) begin
      phase_q <= SID_PH_OPCODE;
    end else if (cs_rise) begin
      phase_q <= SID_PH_IDLE;
    end else if (byte_done) begin
      unique case (phase_q)
        SID_PH_OPCODE: begin
          if (rx_byte == `SID_OP_STAT_RD) begin
            phase_q <= SID_PH_TX;
          end else if (busy_q) begin
            phase_q <= SID_PH_IGNORE;
          end else if (rx_byte == `SID_OP_STAT_WR) begin
            phase_q <= SID_PH_SDATA;
          end else if (rx_byte[7:4] == 4'h0 && (rx_byte[2:0] == `SID_OP_MEM_WR_LO
                       || rx_byte[2:0] == `SID_OP_MEM_RD_LO)) begin
            phase_q   <= SID_PH_ADDR;
            is_read_q <= rx_byte[0];
            addr_hi_q <= rx_byte[3];
          end else begin
            // one-byte commands and unknown codes: rest of frame ignored
            phase_q <= SID_PH_IGNORE;
          end
        end
        SID_PH_ADDR: begin
          phase_q <= is_read_q ? SID_PH_TX : SID_PH_WDATA;
        end
        default: begin
          phase_q <= phase_q; // data phases hold until deselect
        end
      endcase
    end
  end

  // write-enable latch: set and clear commands, cleared by a done write
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      latch_q <= 1'b0;
    end else if (byte_done && phase_q == SID_PH_OPCODE && !busy_q
                 && rx_byte == `SID_OP_SET_LATCH) begin
      latch_q <= 1'b1;
    end else if (byte_done && phase_q == SID_PH_OPCODE && !busy_q
                 && rx_byte == `SID_OP_CLR_LATCH) begin
      latch_q <= 1'b0;
    end else if (mem_commit_out || status_commit_out) begin
      latch_q <= 1'b0;
    end
  end

  // restore pulse as soon as the opcode's last bit is in
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) restore_defaults_out <= 1'b0;
    else restore_defaults_out <= byte_done && phase_q == SID_PH_OPCODE && !busy_q
                                 && rx_byte == `SID_OP_RESTORE;
  end

  // status write: keep the last byte, apply at deselect on whole bytes
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      nv_q              <= `SID_NV_RESET;
      sdata_q           <= 8'h00;
      sdata_got_q       <= 1'b0;
      status_commit_out <= 1'b0;
    end else begin
      status_commit_out <= 1'b0;
      if (cs_fall) begin
        sdata_got_q <= 1'b0;
      end else if (byte_done && phase_q == SID_PH_SDATA) begin
        sdata_q     <= rx_byte;
        sdata_got_q <= 1'b1;
      end else if (cs_rise && phase_q == SID_PH_SDATA && sdata_got_q
                   && bit_cnt_q == 3'h0 && latch_q && !lock_now) begin
        nv_q              <= sdata_q[7:2];
        status_commit_out <= 1'b1;
      end
    end
  end

  // write guard per target address
  always_comb begin
    addr_ok = 1'b0;
    if (addr_q < `SID_REG_BASE) begin
      unique case (nv_q[`SID_NV_BLK_HI:`SID_NV_BLK_LO])
        2'b00:   addr_ok = 1'b1;
        2'b01:   addr_ok = addr_q < `SID_BLK_Q3;
        2'b10:   addr_ok = addr_q < `SID_BLK_HALF;
        2'b11:   addr_ok = 1'b0;
      endcase
    end else if (addr_q < `SID_ROM_BASE) begin
      addr_ok = addr_q >= `SID_REG_FIRST_WR;
    end else if (addr_q >= `SID_HR_BASE && addr_q <= `SID_HR_LAST) begin
      addr_ok = ~nv_q[`SID_NV_RANGE];
    end
  end
  assign push = byte_done && phase_q == SID_PH_WDATA && latch_q && addr_ok;

  // address pointer: writes wrap in a 16-byte segment, reads run on
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_q <= 9'h000;
    end else if (byte_done && phase_q == SID_PH_ADDR) begin
      addr_q <= {addr_hi_q, rx_byte};
    end else if (byte_done && phase_q == SID_PH_WDATA) begin
      addr_q <= {addr_q[8:4], addr_q[3:0] + 4'h1};
    end else if (mem_rd_req_out) begin
      addr_q <= addr_q + 9'h001;
    end
  end

  // write frame: commit on whole bytes, else tell the engine to drop
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pushed_q       <= 1'b0;
      overrun_q      <= 1'b0;
      mem_commit_out <= 1'b0;
      mem_abort_out  <= 1'b0;
    end else begin
      mem_commit_out <= 1'b0;
      mem_abort_out  <= 1'b0;
      if (cs_fall) begin
        pushed_q  <= 1'b0;
        overrun_q <= 1'b0;
      end else if (push) begin
        pushed_q <= pushed_q | fifo_in_ready;
        // a full buffer cannot stall the master, so the frame fails
        overrun_q <= overrun_q | ~fifo_in_ready;
      end else if (cs_rise && phase_q == SID_PH_WDATA && pushed_q) begin
        if (!overrun_q && bit_cnt_q == 3'h0 && latch_q) begin
          mem_commit_out <= 1'b1;
        end else begin
          mem_abort_out <= 1'b1;
        end
      end
    end
  end

  sid_fifo #(.WIDTH(17), .DEPTH(32)) u_fifo (
    .clk_sys_in    (clk_sys_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (push),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    ({addr_q, rx_byte}),
    .out_valid_out (mem_wr_valid_out),
    .out_ready_in  (mem_wr_ready_in),
    .out_data_out  (fifo_out)
  );
  assign {mem_wr_addr_out, mem_wr_data_out} = fifo_out;

  // read strobes: first at the address byte, then one per loaded byte
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_rd_req_out <= 1'b0;
      rd_pend_q      <= 1'b0;
      rd_data_q      <= 8'h00;
    end else begin
      mem_rd_req_out <= (byte_done && phase_q == SID_PH_ADDR && is_read_q)
                        || (sck_fall && phase_q == SID_PH_TX && !tx_src_stat_q
                            && tx_cnt_q == 3'h0);
      rd_pend_q <= mem_rd_req_out;
      if (rd_pend_q) rd_data_q <= mem_rd_data_in;
    end
  end
  assign mem_rd_addr_out = addr_q;
  assign next_byte = tx_src_stat_q ? stat_byte : rd_data_q;

  // transmit shifter: new bit after each falling edge, msb first
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_cnt_q      <= 3'h0;
      tx_sh_q       <= 7'h00;
      tx_src_stat_q <= 1'b0;
      so_out        <= 1'b0;
    end else if (cs_fall) begin
      tx_cnt_q <= 3'h0;
    end else if (byte_done && phase_q == SID_PH_OPCODE) begin
      tx_src_stat_q <= (rx_byte == `SID_OP_STAT_RD);
    end else if (sck_fall && phase_q == SID_PH_TX) begin
      tx_cnt_q <= tx_cnt_q + 3'h1;
      if (tx_cnt_q == 3'h0) begin
        // status reloads each byte so busy can be polled without a new opcode
        so_out  <= next_byte[7];
        tx_sh_q <= next_byte[6:0];
      end else begin
        so_out  <= tx_sh_q[6];
        tx_sh_q <= {tx_sh_q[5:0], 1'b0};
      end
    end
  end

  // output enable follows the filtered select
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) so_oe_n_out <= 1'b1;
    else           so_oe_n_out <= cs_f;
  end

  // status fields out to the guard and watchdog logic
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_lock_enable_out <= 1'b0;
      high_range_guard_out   <= 1'b0;
      dog_timeout_sel_out    <= 2'h0;
      block_guard_sel_out    <= 2'h0;
    end else begin
      status_lock_enable_out <= nv_q[`SID_NV_LOCK];
      high_range_guard_out   <= nv_q[`SID_NV_RANGE];
      dog_timeout_sel_out    <= nv_q[`SID_NV_DOG_HI:`SID_NV_DOG_LO];
      block_guard_sel_out    <= nv_q[`SID_NV_BLK_HI:`SID_NV_BLK_LO];
    end
  end

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  a_opcode_first: assert property (cs_fall |=> phase_q == SID_PH_OPCODE)
    else $error("frame does not start at opcode");
  a_latch_set: assert property (byte_done && phase_q == SID_PH_OPCODE && !busy_q
      && rx_byte == `SID_OP_SET_LATCH |=> latch_q)
    else $error("set command did not set latch");
  a_latch_clear: assert property (byte_done && phase_q == SID_PH_OPCODE && !busy_q
      && rx_byte == `SID_OP_CLR_LATCH |=> !latch_q)
    else $error("clear command left latch set");
  a_status_load: assert property (status_commit_out |-> nv_q == sdata_q[7:2])
    else $error("status bits differ from received byte");
  a_lock_holds: assert property (cs_rise && lock_now |=> $stable(nv_q))
    else $error("locked status bits changed");
  a_push_latch: assert property (push |-> latch_q && phase_q == SID_PH_WDATA)
    else $error("write buffered without latch");
  a_commit_clears: assert property (mem_commit_out |=> !latch_q ##1 !mem_commit_out)
    else $error("latch survived a committed write");
  a_release_out: assert property (cs_f [*2] |-> so_oe_n_out)
    else $error("output driven while deselected");
  a_restore_pulse: assert property (restore_defaults_out |=> !restore_defaults_out)
    else $error("restore pulse too long");
  a_ignore_frame: assert property (phase_q == SID_PH_IGNORE && !cs_rise
      |=> $stable(latch_q) && $stable(nv_q) && !mem_rd_req_out)
    else $error("ignored frame changed state");

  c_set_latch: cover property (latch_q && !$past(latch_q));
  c_status_wr: cover property (status_commit_out);
  c_mem_commit: cover property (mem_commit_out);
  c_read_strobe: cover property (mem_rd_req_out ##[1:400] mem_rd_req_out);
endmodule : sid_decoder

// ---- testbench/sid_spi_master.sv ----
`timescale 1ns/1ps
// serial master: select, clock, data out; reply sampled in
module sid_spi_master (
  input  wire logic clk_in,   // paces the bits
  input  wire logic so_in,    // slave reply
  output logic      csn_out,  // select, low active
  output logic      sck_out,  // still between frames
  output logic      si_out    // data to slave
);
  logic idle_hi; // rest level of the clock, picks the mode
  initial begin
    csn_out = 1'b1;
    sck_out = 1'b0;
    si_out  = 1'b0;
    idle_hi = 1'b0;
  end
  // n whole bytes, 8 clocks per bit
  task automatic frame(input logic [7:0] tx[40], input int n, output logic [7:0] rx[40]);
    rx = '{default: 8'h00};
    sck_out = idle_hi;  // steady before select falls
    repeat (8) @(negedge clk_in);
    csn_out = 1'b0;
    repeat (4) @(negedge clk_in);
    for (int b = 0; b < n; b++) begin
      for (int i = 7; i >= 0; i--) begin
        sck_out = 1'b0;
        si_out  = tx[b][i];  // msb first, held over the rise
        repeat (4) @(negedge clk_in);
        sck_out = 1'b1;
        repeat (4) @(negedge clk_in);
        rx[b][i] = so_in;  // late sample: filtered reply lags ~5 clocks
      end
    end
    sck_out = idle_hi;
    repeat (4) @(negedge clk_in);
    csn_out = 1'b1;
    si_out  = ~si_out;  // no stale bit after deselect
    repeat (8) @(negedge clk_in);
  endtask : frame
endmodule : sid_spi_master

// ---- testbench/tb_top.sv ----
`timescale 1ns/1ps
// decoder bench, master model on the far side
module tb_top;
  typedef struct packed {logic pin; logic [7:0] op, arg, exp;} sid_row_t;
  logic        clk_sys, rst_n, csn, sck, si, so, so_oe_n, wp_n, busy, mode_hi;
  logic        wr_valid, wr_ready, commit, abort, st_commit, rd_req, restore;
  logic        lock, hr_guard;
  logic [1:0]  dog_sel, blk_sel;
  logic [8:0]  wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data;
  logic [7:0]  tx [40];
  logic [7:0]  rx [40];
  logic [16:0] words [$];  // words the engine took
  int          error_cnt, tests_run, commit_cnt, restore_cnt;
  int          abort_cnt, st_cnt, oe_low_cnt;  // engine pulses, cycles with so driven
  sid_row_t    rows [11] = '{
    '{1'b1, 8'h06, 8'h00, 8'h02},
    '{1'b1, 8'h04, 8'h00, 8'h00},
    '{1'b1, 8'h01, 8'hfc, 8'h00},  // no latch
    '{1'b1, 8'h06, 8'h00, 8'h02},
    '{1'b1, 8'h01, 8'h3f, 8'h3c},
    '{1'b1, 8'h99, 8'h06, 8'h3c},
    '{1'b1, 8'h06, 8'h00, 8'h3e},
    '{1'b1, 8'h01, 8'h80, 8'h80},
    '{1'b0, 8'h06, 8'h00, 8'h82},
    '{1'b0, 8'h01, 8'h40, 8'h82},  // pin low refuses
    '{1'b1, 8'h01, 8'h00, 8'h00}
  };
  initial clk_sys = 1'b0;
  always #20 clk_sys = ~clk_sys;
  sid_decoder uut (
    .clk_sys_in(clk_sys), .rst_n_in(rst_n), .chip_select_low_in(csn), .sck_in(sck),
    .si_in(si), .hw_protect_pin_low_in(wp_n), .so_out(so), .so_oe_n_out(so_oe_n),
    .mode_idle_high_out(mode_hi), .nv_busy_in(busy), .mem_wr_valid_out(wr_valid),
    .mem_wr_ready_in(wr_ready), .mem_wr_addr_out(wr_addr), .mem_wr_data_out(wr_data),
    .mem_commit_out(commit), .mem_abort_out(abort), .status_commit_out(st_commit),
    .mem_rd_req_out(rd_req), .mem_rd_addr_out(rd_addr), .mem_rd_data_in(rd_data),
    .restore_defaults_out(restore), .status_lock_enable_out(lock),
    .high_range_guard_out(hr_guard), .dog_timeout_sel_out(dog_sel),
    .block_guard_sel_out(blk_sel));
  sid_spi_master mst (.clk_in(clk_sys), .so_in(so), .csn_out(csn), .sck_out(sck), .si_out(si));
  // memory: data valid the cycle after the strobe
  always @(negedge clk_sys) begin
    if (rd_req) rd_data <= {rd_addr[8] ^ rd_addr[7], rd_addr[6:0]};
  end
  // engine side: take words, count pulses
  always @(posedge clk_sys) begin
    if (wr_valid && wr_ready) words.push_back({wr_addr, wr_data});
    if (commit) commit_cnt++;
    if (restore) restore_cnt++;
    if (abort) abort_cnt++;
    if (st_commit) st_cnt++;
    if (!so_oe_n) oe_low_cnt++;
  end
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("FAIL %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic send(input logic [7:0] a, input logic [7:0] b, input int n);
    tx[0] = a;
    tx[1] = b;
    mst.frame(tx, n, rx);
  endtask : send
  task automatic status_is(input logic [7:0] exp);
    send(8'h05, 8'h00, 2);
    check(17'(rx[1]), 17'(exp));
    check(17'(so_oe_n), 17'h1);
  endtask : status_is
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // whole run is about 10k clocks; cut-off near five times that
  initial begin
    #2000000;
    error_cnt++;
    $display("FAIL %0t watchdog expired", $time);
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    busy = 1'b0;
    wr_ready = 1'b1;
    rd_data = 8'h00;
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    check(17'(so_oe_n), 17'h1);
    foreach (rows[i]) begin
      wp_n = rows[i].pin;
      send(rows[i].op, rows[i].arg, 2);
      status_is(rows[i].exp);
      check(17'({lock, hr_guard, dog_sel, blk_sel}), 17'(rows[i].exp[7:2]));
    end
    check(17'(st_cnt), 17'd3);
    check(17'(mode_hi), 17'h0);
    // stalled engine: buffer filled to 32, then drained
    send(8'h06, 8'h00, 1);
    wr_ready = 1'b0;
    for (int k = 0; k < 32; k++) tx[k + 2] = 8'(k);
    send(8'h02, 8'h10, 34);
    check(17'(words.size()), 17'h0);
    check(17'(wr_valid), 17'h1);
    wr_ready = 1'b1;
    for (int t = 0; t < 100 && words.size() < 32; t++) @(negedge clk_sys);
    check(17'(words.size()), 17'd32);
    foreach (words[k]) check(words[k], {9'h010 | 9'(k % 16), 8'(k)});
    check(17'(commit_cnt), 17'h1);
    status_is(8'h00);
    // guarded block and high range refuse, latch kept
    send(8'h06, 8'h00, 1);
    send(8'h01, 8'h44, 2);
    check(17'(st_cnt), 17'd4);
    check(17'(hr_guard), 17'h1);
    send(8'h06, 8'h00, 1);
    tx[2] = 8'h77;
    send(8'h02, 8'hc5, 3);
    send(8'h0a, 8'h20, 3);
    check(17'(words.size() + commit_cnt), 17'd33);
    status_is(8'h46);
    // busy: only the status read acts
    busy = 1'b1;
    status_is(8'h47);
    send(8'h04, 8'h00, 1);
    busy = 1'b0;
    status_is(8'h46);
    // a full buffer cannot stall the master: 33 bytes abort the frame
    wr_ready = 1'b0;
    for (int k = 0; k < 33; k++) tx[k + 2] = 8'(k);
    send(8'h02, 8'h10, 35);
    check(17'(abort_cnt), 17'h1);
    check(17'(commit_cnt), 17'h1);
    wr_ready = 1'b1;
    status_is(8'h46);
    // read at 120h in mode (1,1)
    mst.idle_hi = 1'b1;
    tx[2] = 8'h00;
    tx[3] = 8'h00;
    send(8'h0b, 8'h20, 4);
    check(17'({rx[2], rx[3]}), 17'ha0a1);
    check(17'(mode_hi), 17'h1);
    mst.idle_hi = 1'b0;
    send(8'h07, 8'h00, 1);
    check(17'(restore_cnt), 17'h1);
    rst_n = 1'b0;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (8) @(negedge clk_sys);
    status_is(8'h00);
    check(17'({lock, hr_guard, dog_sel, blk_sel}), 17'h0);
    check(17'(oe_low_cnt > 0), 17'h1);
    wrap_up();
  end
endmodule : tb_top
